// >>> hdl/wdh_watchdog.sv
// Behaviour
// - count drops every 16384 clocks; reset when bit six falls from 40h.
// - max timeout is base plus 16384 per count for small counts.
// - larger counts add (192+lsb)*64 periods per quotient, floored.
// - slow and wait modes leave the counter and reset untouched.
// - plain halt: no reset, one decrement, then frozen until wake; here that decrement from 40h still fires a reset.
// - external wake from plain halt resumes after 256 or 4096 clocks.
// - reset ending plain halt disables watchdog unless hardware option.
// - halt with halt-reset option and no timebase irq forces reset.
// - halt with timebase irq enable enters active halt, counter frozen.
// - interrupt ending active halt resumes counting at once.
// - reset ending active halt resumes after 256 or 4096 clocks.
// - hardware option keeps watchdog active, activation bit ignored.
// - activation bit set by software write only, cleared by reset.
// - control register reads 7Fh after reset.
// - timebase irq enable turns halt into active halt.
// - timebase select picks constants 4/59, 8/53, 20/35, 49/54.
// - write with activation set and bit six clear resets at once.
// - watchdog reset drives reset pin low for about 30 us.
//
// Chosen here: the Wishbone interface to the registers.
`timescale 1ns/10ps
`include "wdh_defines.svh"
module wdh_watchdog
   import wdh_pkg::*;
#(
   parameter logic [15:0] PRESCALE = `WDH_PRESCALE,
   parameter int PULSE_CYC = `WDH_PULSE_CYC
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [9:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   input wire logic halt_req_i,
   input wire logic ext_irq_i,
   input wire logic tb_irq_i,
   input wire logic hw_wdg_opt_i,
   input wire logic halt_rst_opt_i,
   input wire logic long_wake_i,
   input wire logic cpu_rst_i,
   output logic rst_pin_n_o,
   output logic halted_o,
   output logic [1:0] timebase_select_o
);
   // ----------------------------------------
   // bus decode
   // ----------------------------------------
   logic act_r;
   logic [6:0] cnt_r;
   logic [6:0] cnt_nxt;
   logic tie_r;
   logic [1:0] tbs_r;
   logic ack_r;
   logic [31:0] rdat_r;
   logic [31:0] rdat_nxt;
   logic fire_r;
   logic [12:0] wake_r;
   logic hw_s1_r, hw_s2_r, hr_s1_r, hr_s2_r, lw_s1_r, lw_s2_r;
   logic hq_s1_r, hq_s2_r, ei_s1_r, ei_s2_r, ti_s1_r, ti_s2_r;
   logic cr_s1_r, cr_s2_r, hq_d_r;
   wdh_state_type st_r;
   wdh_state_type st_nxt;
   wire logic req = wb_cyc_i & wb_stb_i & ~ack_r;
   wire logic sel_ctrl = (wb_adr_i == `WDH_CTRL_ADDR);
   wire logic sel_opt = (wb_adr_i == `WDH_OPT_ADDR);
   wire logic sel_stat = (wb_adr_i == `WDH_STAT_ADDR);
   wire logic wr = req & wb_we_i & wb_sel_i[0];
   wire logic wr_ctrl = wr & sel_ctrl;
   wire logic wr_opt = wr & sel_opt;
   wire logic enabled = act_r | hw_s2_r;
   wire logic tick;
   wire logic running = (st_r == WDH_RUN);
   wire logic [7:0] ctrl_val = {act_r, cnt_r};
   // ----------------------------------------
   // halt mode decode
   // ----------------------------------------
   // edge only: a held request must not refire the reset pulse
   wire logic halt_go = hq_s2_r & ~hq_d_r & running;
   wire logic halt_rst = halt_go & ~tie_r & hr_s2_r;
   wire logic halt_full = halt_go & ~tie_r & ~hr_s2_r;
   wire logic halt_act = halt_go & tie_r;
   wire logic expire = tick & enabled & (st_r != WDH_HALT) &
      (cnt_r == 7'h40);
   wire logic halt_expire = halt_full & enabled & (cnt_r == 7'h40);
   wire logic sw_rst = wr_ctrl & wb_dat_i[`WDH_ACT_BIT] &
      ~wb_dat_i[`WDH_MSB_BIT];
   wire logic fire = expire | sw_rst | halt_expire |
      (halt_rst & enabled);
   wire logic [12:0] wake_len = lw_s2_r ? `WDH_WAKE_LONG :
      `WDH_WAKE_SHORT;

   // ----------------------------------------
   // pin synchronisers
   // ----------------------------------------
   always_ff @(posedge clk_i) begin
      hw_s1_r <= hw_wdg_opt_i;
      hw_s2_r <= hw_s1_r;
      hr_s1_r <= halt_rst_opt_i;
      hr_s2_r <= hr_s1_r;
      lw_s1_r <= long_wake_i;
      lw_s2_r <= lw_s1_r;
      hq_s1_r <= halt_req_i;
      hq_s2_r <= hq_s1_r;
      hq_d_r <= hq_s2_r;
      ei_s1_r <= ext_irq_i;
      ei_s2_r <= ei_s1_r;
      ti_s1_r <= tb_irq_i;
      ti_s2_r <= ti_s1_r;
      cr_s1_r <= cpu_rst_i;
      cr_s2_r <= cr_s1_r;
   end

   // ----------------------------------------
   // halt state machine
   // ----------------------------------------
   always_comb begin
      st_nxt = st_r;
      case (st_r)
         WDH_RUN: begin
            // slow and wait never reach here; counting goes on
            if (halt_full)
               st_nxt = WDH_HALT;
            else if (halt_act)
               st_nxt = WDH_AHALT;
         end
         WDH_HALT: begin
            if (ei_s2_r | cr_s2_r)
               st_nxt = WDH_WAKE;
         end
         WDH_AHALT: begin
            if (cr_s2_r)
               st_nxt = WDH_WAKE;
            else if (ei_s2_r | ti_s2_r)
               st_nxt = WDH_RUN;
         end
         WDH_WAKE: begin
            if (wake_r == 13'h0001)
               st_nxt = WDH_RUN;
         end
         default: st_nxt = WDH_RUN;
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         st_r <= WDH_RUN;
         wake_r <= 13'h0000;
      end else begin
         st_r <= st_nxt;
         if ((st_r == WDH_HALT) || (st_r == WDH_AHALT))
            wake_r <= wake_len;
         else if (wake_r != 13'h0000)
            wake_r <= wake_r - 13'h0001;
      end
   end

   // ----------------------------------------
   // counter and control register
   // ----------------------------------------
   always_comb begin
      cnt_nxt = cnt_r;
      if (wr_ctrl)
         cnt_nxt = wb_dat_i[6:0];
      else if (halt_full)
         cnt_nxt = cnt_r - 7'h01;
      else if (tick && running)
         cnt_nxt = cnt_r - 7'h01;
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         act_r <= 1'b0;
         cnt_r <= `WDH_CNT_RESET;
         tie_r <= 1'b0;
         tbs_r <= 2'b00;
      end else if (cr_s2_r && (st_r != WDH_RUN)) begin
         act_r <= 1'b0;
         cnt_r <= `WDH_CNT_RESET;
      end else begin
         cnt_r <= cnt_nxt;
         if (wr_ctrl && wb_dat_i[`WDH_ACT_BIT])
            act_r <= 1'b1;
         if (wr_opt) begin
            tie_r <= wb_dat_i[`WDH_TIE_BIT];
            tbs_r <= wb_dat_i[`WDH_TBS_HI:`WDH_TBS_LO];
         end
      end
   end

   // ----------------------------------------
   // bus answer
   // ----------------------------------------
   always_comb begin
      rdat_nxt = 32'h0000_0000;
      if (sel_ctrl)
         rdat_nxt = {24'h00_0000, ctrl_val};
      else if (sel_opt)
         rdat_nxt = {29'h0000_0000, tbs_r, tie_r};
      else if (sel_stat)
         rdat_nxt = {28'h000_0000, st_r};
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_r <= 1'b0;
         rdat_r <= 32'h0000_0000;
         fire_r <= 1'b0;
         halted_o <= 1'b0;
         timebase_select_o <= 2'b00;
      end else begin
         ack_r <= req;
         if (req)
            rdat_r <= rdat_nxt;
         fire_r <= fire;
         halted_o <= (st_nxt == WDH_HALT) || (st_nxt == WDH_AHALT);
         timebase_select_o <= tbs_r;
      end
   end

   assign wb_ack_o = ack_r;
   assign wb_dat_o = rdat_r;

   // ----------------------------------------
   // submodules
   // ----------------------------------------
   wdh_prescaler #(
      .DIV(PRESCALE)
   ) u_pre (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .run_i(running),
      .tick_o(tick)
   );

   wdh_reset_pulse #(
      .CYC(PULSE_CYC)
   ) u_pulse (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .fire_i(fire_r),
      .rst_pin_n_o(rst_pin_n_o)
   );
endmodule

// >>> hdl/wdh_defines.svh
`ifndef WDH_DEFINES_SVH
`define WDH_DEFINES_SVH
// ----------------------------------------
// register map, byte addresses (index times four)
// ----------------------------------------
`define WDH_CTRL_INDEX 8'h2a
`define WDH_CTRL_ADDR 10'h0a8
`define WDH_OPT_ADDR 10'h0ac
`define WDH_STAT_ADDR 10'h0b0
// ----------------------------------------
// control register fields and reset value
// ----------------------------------------
`define WDH_ACT_BIT 7
`define WDH_MSB_BIT 6
`define WDH_CTRL_RESET 8'h7f
`define WDH_CNT_RESET 7'h7f
// option register fields
`define WDH_TIE_BIT 0
`define WDH_TBS_LO 1
`define WDH_TBS_HI 2
// ----------------------------------------
// timing
// ----------------------------------------
`define WDH_PRESCALE 16'h4000
`define WDH_PULSE_NS 30000
`define WDH_CLK_NS 50
`define WDH_PULSE_CYC ((`WDH_PULSE_NS + `WDH_CLK_NS - 1) / `WDH_CLK_NS)
`define WDH_WAKE_SHORT 13'h0100
`define WDH_WAKE_LONG 13'h1000
`endif

// >>> hdl/wdh_pkg.sv
package wdh_pkg;
   typedef enum logic [3:0] {
      WDH_RUN = 4'b0001,
      WDH_HALT = 4'b0010,
      WDH_AHALT = 4'b0100,
      WDH_WAKE = 4'b1000
   } wdh_state_type;
endpackage

// >>> hdl/wdh_prescaler.sv
`timescale 1ns/10ps
`include "wdh_defines.svh"
// divider, advancing only while run_i is high, producing a one-cycle tick every DIV clocks (16384 by default)
module wdh_prescaler
   import wdh_pkg::*;
#(
   parameter logic [15:0] DIV = `WDH_PRESCALE
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic run_i,
   output logic tick_o
);
   logic [15:0] cnt_r;
   logic [15:0] cnt_nxt;
   wire logic last = (cnt_r == DIV - 16'h0001);
   assign cnt_nxt = last ? 16'h0000 : cnt_r + 16'h0001;
   // never cleared by register writes, so timeout lies between min and max
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cnt_r <= 16'h0000;
         tick_o <= 1'b0;
      end else if (run_i) begin
         cnt_r <= cnt_nxt;
         tick_o <= last;
      end else begin
         tick_o <= 1'b0;
      end
   end
endmodule

// >>> hdl/wdh_reset_pulse.sv
`timescale 1ns/10ps
`include "wdh_defines.svh"
// stretches a reset request into a low pulse on the reset pin
module wdh_reset_pulse
   import wdh_pkg::*;
#(
   parameter int CYC = `WDH_PULSE_CYC
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic fire_i,
   output logic rst_pin_n_o
);
   logic [9:0] cnt_r;
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cnt_r <= 10'h000;
         rst_pin_n_o <= 1'b1;
      end else if (fire_i) begin
         cnt_r <= 10'(CYC - 1);
         rst_pin_n_o <= 1'b0;
      end else if (cnt_r != 10'h000) begin
         cnt_r <= cnt_r - 10'h001;
      end else begin
         rst_pin_n_o <= 1'b1;
      end
   end
endmodule

// >>> test/wdh_watchdog_props.sv
`timescale 1ns/10ps
`include "wdh_defines.svh"
// ----------------------------------
// port checks
// ----------------------------------
module wdh_watchdog_props #(
   parameter int PULSE_CYC = 4
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [9:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic wb_ack_o,
   input wire logic ext_irq_i,
   input wire logic rst_pin_n_o,
   input wire logic halted_o,
   input wire logic [1:0] timebase_select_o
);
   logic [15:0] low_r;
   wire logic wr = wb_ack_o && wb_we_i && wb_sel_i[0];
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   // low time counted here, too long for a repetition
   always_ff @(posedge clk_i) begin
      if (rst_i || rst_pin_n_o) low_r <= 16'h0000;
      else low_r <= low_r + 16'h0001;
   end
   property p_ack_cause;
      wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o;
   endproperty
   a_ack_cause: assert property (p_ack_cause) else $error("ack late");
   property p_ack_pulse;
      wb_ack_o |=> !wb_ack_o;
   endproperty
   a_ack_pulse: assert property (p_ack_pulse) else $error("ack long");
   property p_unmapped;
      wb_ack_o && !wb_we_i && wb_adr_i == 10'h0fc |-> wb_dat_o == 0;
   endproperty
   a_unmapped: assert property (p_unmapped) else $error("bad read");
   property p_sw_reset;
      wr && wb_adr_i == `WDH_CTRL_ADDR && wb_dat_i[7:6] == 2'b10
         |-> ##[1:3] !rst_pin_n_o;
   endproperty
   a_sw_reset: assert property (p_sw_reset) else $error("no reset");
   property p_tbs;
      wr && wb_adr_i == `WDH_OPT_ADDR
         |-> ##2 timebase_select_o == $past(wb_dat_i[2:1], 2);
   endproperty
   a_tbs: assert property (p_tbs) else $error("timebase wrong");
   property p_wake;
      halted_o && ext_irq_i |-> ##[1:5] !halted_o;
   endproperty
   a_wake: assert property (p_wake) else $error("no wake");
   property p_pulse_len;
      low_r <= PULSE_CYC;
   endproperty
   a_pulse_len: assert property (p_pulse_len) else $error("pulse long");
   property p_pulse_end;
      $rose(rst_pin_n_o) |-> low_r == PULSE_CYC;
   endproperty
   a_pulse_end: assert property (p_pulse_end) else $error("pulse short");
endmodule

// >>> test/wdh_watchdog_test.sv
`timescale 1ns/10ps
`include "wdh_defines.svh"
module wdh_watchdog_test;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic cyc = 1'b0, we = 1'b0, hreq = 1'b0, eirq = 1'b0;
   logic tirq = 1'b0, hwo = 1'b0, hro = 1'b0;
   logic lw = 1'b0, crst = 1'b0;
   logic [9:0] adr = 10'h000;
   logic [31:0] dat = 32'h0000_0000;
   logic [31:0] rdat;
   logic ack, pin, halted;
   logic [1:0] tbs;
   logic [7:0] q, q1;
   int err_total = 0;
   int tests_run = 0;
   always #25 clk_i = ~clk_i;
   // short prescale and pulse keep the run brief
   wdh_watchdog #(.PRESCALE(16'h0010), .PULSE_CYC(4)) i_dut (
      .clk_i, .rst_i, .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we),
      .wb_adr_i(adr), .wb_sel_i(4'h1), .wb_dat_i(dat), .wb_dat_o(rdat),
      .wb_ack_o(ack), .halt_req_i(hreq), .ext_irq_i(eirq), .tb_irq_i(tirq),
      .hw_wdg_opt_i(hwo), .halt_rst_opt_i(hro), .long_wake_i(lw),
      .cpu_rst_i(crst), .rst_pin_n_o(pin), .halted_o(halted),
      .timebase_select_o(tbs));
   // ----------------------------------
   // tasks
   // ----------------------------------
   task automatic conclude;
      $display("checks %0d errors %0d", tests_run, err_total);
      if (err_total == 0 && tests_run > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   task automatic fail(input string s);
      err_total++;
      $display("wrong value at %0t: %s", $time, s);
   endtask
   task automatic chk(input logic [7:0] g, input logic [7:0] e);
      tests_run++;
      if (g !== e) fail($sformatf("got %h expected %h", g, e));
   endtask
   task automatic wt(input int n);
      repeat (n) @(posedge clk_i);
   endtask
   task automatic wb(input logic w, input logic [9:0] a, input logic [7:0] d);
      int n;
      n = 0;
      cyc <= 1'b1;
      we <= w;
      adr <= a;
      dat <= {24'h00_0000, d};
      do begin
         @(posedge clk_i);
         n++;
      end while (ack !== 1'b1 && n < 20);
      q = rdat[7:0];
      cyc <= 1'b0;
      if (ack !== 1'b1) begin
         fail("no ack");
         conclude;
      end
      @(posedge clk_i);
   endtask
   task automatic rd(input logic [9:0] a, input logic [7:0] e);
      wb(1'b0, a, 8'h00);
      chk(q, e);
   endtask
   // which selects halted, else the reset pin
   task automatic await(input logic which, v, input int lo, hi);
      int n;
      n = 0;
      while ((which ? halted : pin) !== v && n < hi) begin
         @(posedge clk_i);
         n++;
      end
      tests_run++;
      if ((which ? halted : pin) !== v || n < lo) begin
         fail("event timing");
         conclude;
      end
   endtask
   task automatic quiet(input int n);
      int bad;
      bad = 0;
      repeat (n) begin
         @(posedge clk_i);
         if (pin !== 1'b1) bad = 1;
      end
      chk(bad[7:0], 8'h00);
   endtask
   task automatic halt;
      hreq <= 1'b1;
      wt(3);
      hreq <= 1'b0;
   endtask
   task automatic sysrst;
      rst_i <= 1'b1;
      wt(3);
      rst_i <= 1'b0;
   endtask
   // ----------------------------------
   // sequence
   // ----------------------------------
   initial begin
      sysrst;
      rd(`WDH_CTRL_ADDR, 8'h7f);
      rd(`WDH_OPT_ADDR, 8'h00);
      rd(10'h0fc, 8'h00);
      wb(1'b1, `WDH_CTRL_ADDR, 8'h00);
      quiet(100);
      wb(1'b1, `WDH_CTRL_ADDR, 8'hc5);
      wb(1'b1, `WDH_CTRL_ADDR, 8'h41);
      wb(1'b0, `WDH_CTRL_ADDR, 8'h00);
      chk(q & 8'h80, 8'h80);
      await(1'b0, 1'b0, 10, 40);
      wt(8);
      sysrst;
      rd(`WDH_CTRL_ADDR, 8'h7f);
      wb(1'b1, `WDH_CTRL_ADDR, 8'h80);
      await(1'b0, 1'b0, 0, 4);
      wt(8);
      sysrst;
      for (int i = 0; i < 4; i++) begin
         wb(1'b1, `WDH_OPT_ADDR, 8'(i * 2));
         wt(2);
         chk({6'h00, tbs}, 8'(i));
      end
      hwo <= 1'b1;
      sysrst;
      wb(1'b1, `WDH_CTRL_ADDR, 8'h41);
      await(1'b0, 1'b0, 10, 40);
      wt(8);
      hwo <= 1'b0;
      sysrst;
      for (int k = 0; k < 2; k++) begin
         wb(1'b1, `WDH_OPT_ADDR, 8'(1 - k));
         wb(1'b1, `WDH_CTRL_ADDR, 8'hff);
         halt;
         await(1'b1, 1'b1, 1, 10);
         wb(1'b0, `WDH_CTRL_ADDR, 8'h00);
         q1 = q;
         quiet(100);
         rd(`WDH_CTRL_ADDR, q1);
         if (k == 0) tirq <= 1'b1;
         else eirq <= 1'b1;
         await(1'b1, 1'b0, 1, 6);
         tirq <= 1'b0;
         eirq <= 1'b0;
         // plain halt wakes through the 256-cycle delay
         if (k == 1) rd(`WDH_CTRL_ADDR, q1);
         wt(k == 0 ? 40 : 290);
         wb(1'b0, `WDH_CTRL_ADDR, 8'h00);
         chk(8'(q < q1), 8'h01);
      end
      hro <= 1'b1;
      wb(1'b1, `WDH_CTRL_ADDR, 8'hff);
      halt;
      await(1'b0, 1'b0, 1, 10);
      chk({7'h00, halted}, 8'h00);
      wt(8);
      // reset ending plain halt, long wake delay
      hro <= 1'b0;
      lw <= 1'b1;
      wb(1'b1, `WDH_CTRL_ADDR, 8'hff);
      halt;
      await(1'b1, 1'b1, 1, 10);
      crst <= 1'b1;
      await(1'b1, 1'b0, 1, 6);
      crst <= 1'b0;
      rd(`WDH_CTRL_ADDR, 8'h7f);
      wt(1000);
      rd(`WDH_CTRL_ADDR, 8'h7f);
      wt(3300);
      wb(1'b0, `WDH_CTRL_ADDR, 8'h00);
      chk(8'(q < 8'h7f), 8'h01);
      conclude;
   end
endmodule
bind wdh_watchdog wdh_watchdog_props #(.PULSE_CYC(PULSE_CYC)) i_props (
   .clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
   .wb_dat_i, .wb_dat_o, .wb_ack_o, .ext_irq_i, .rst_pin_n_o, .halted_o,
   .timebase_select_o);
